// File: serial_rx_crc_alarm_lane_status.sv
// CRC alarm, lane arrival capture and lane polarity inversion for the serial receiver
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module serial_rx_crc_alarm_lane_status
  import serial_rx_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Lane data
  input wire logic [LANES-1:0] lane_raw,
  output logic [LANES-1:0] lane_bits,
  // Multiblock CRC verdicts
  input wire mb_report_t mb_report,
  // Elastic buffer release and arrival times
  input wire logic lanes_ready,
  input wire logic release_try,
  input wire logic [LANES-1:0][ARR_W-1:0] lane_arrival_in,
  // Status
  output logic crc_alarm,
  output logic arrival_times_ready,
  output logic link_enable,
  output logic link_soft_reset,
  output logic irq
);

  link_ctrl_t ctrl_reg;
  crc_alarm_thresholds_t crc_alarm_thresholds_reg;
  logic [DATA_W-1:0] pol_reg;
  logic [6:0] arr_rsvd_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [ERR_W-1:0] err_cnt_reg;
  logic [RUN_W-1:0] run_cnt_reg;
  logic alarm_reg;
  logic ready_reg;
  logic [ARR_W-1:0] arr_reg [LANES];
  logic [DATA_W-1:0] rdata_next;
  logic [LANES-1:0] lane_bits_reg;
  logic irq_reg;
  logic link_on;
  logic capture;
  logic err_mb;
  logic clean_mb;
  logic alarm_set;
  logic ready_set;
  logic [ERR_W-1:0] err_inc;
  logic [RUN_W-1:0] run_inc;
  logic [IRQ_W-1:0] irq_event;

  wire wr_ctrl = reg_wr && (reg_addr == ADDR_LINK_CTRL);
  wire wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
  wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
  wire wr_th = reg_wr && (reg_addr == ADDR_CRC_ALARM_THRESHOLDS);
  wire wr_arr = reg_wr && (reg_addr == ADDR_ARR_STAT);
  wire wr_pol = reg_wr && (reg_addr == ADDR_POL);

  assign link_on = ctrl_reg.enable && !ctrl_reg.soft_reset;
  assign err_mb = link_on && mb_report.valid && mb_report.crc_err;
  assign clean_mb = link_on && mb_report.valid && !mb_report.crc_err;
  assign err_inc = (err_cnt_reg == ERR_MAX) ? ERR_MAX : err_cnt_reg + ERR_ONE;
  assign run_inc = run_cnt_reg + RUN_ONE;
  assign capture = link_on && lanes_ready && release_try && !ready_reg;
  assign alarm_set = err_mb && !alarm_reg && (err_inc >= THR_COUNT[crc_alarm_thresholds_reg.thr]);
  assign ready_set = capture;
  assign irq_event = {ready_set, alarm_set};

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= LINK_CTRL_RESET;
    end else if (clk_en && wr_ctrl) begin
      ctrl_reg <= reg_wdata[$bits(link_ctrl_t)-1:0];
    end
  end

  // Threshold, polarity and reserved storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_alarm_thresholds_reg <= CRC_ALARM_THRESHOLDS_RESET;
      pol_reg <= POL_RESET;
      arr_rsvd_reg <= ARR_RSVD_RESET;
    end else if (clk_en) begin
      if (wr_th) begin
        crc_alarm_thresholds_reg <= reg_wdata[$bits(crc_alarm_thresholds_t)-1:0];
      end
      if (wr_pol) begin
        pol_reg <= reg_wdata;
      end
      if (wr_arr) begin
        arr_rsvd_reg <= reg_wdata[7:1];
      end
    end
  end

  // Error counter and clean run counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_reg <= '0;
      run_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!link_on) begin
        err_cnt_reg <= '0;
        run_cnt_reg <= '0;
      end else if (err_mb) begin
        err_cnt_reg <= err_inc;
        run_cnt_reg <= '0;
      end else if (clean_mb) begin
        if (run_inc >= REC_COUNT[crc_alarm_thresholds_reg.rec]) begin
          err_cnt_reg <= '0;
          run_cnt_reg <= '0;
        end else begin
          run_cnt_reg <= run_inc;
        end
      end
    end
  end

  // CRC alarm
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else if (clk_en) begin
      if (!link_on) begin
        alarm_reg <= 1'b0;
      end else if (err_mb && (err_inc >= THR_COUNT[crc_alarm_thresholds_reg.thr])) begin
        alarm_reg <= 1'b1;
      end else if (clean_mb && (run_inc >= REC_COUNT[crc_alarm_thresholds_reg.rec])) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  // Arrival ready flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
    end else if (clk_en) begin
      // disable or soft reset clears flag
      if (!ctrl_reg.enable || ctrl_reg.soft_reset) begin
        ready_reg <= 1'b0;
      end else if (capture) begin
        ready_reg <= 1'b1;
      end
    end
  end

  // Per lane arrival capture
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_arr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          arr_reg[gi] <= ARR_RESET;
        end else if (clk_en && capture) begin
          arr_reg[gi] <= lane_arrival_in[gi];
        end
      end
    end
  endgenerate

  // Lane polarity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_bits_reg <= '0;
    end else if (clk_en) begin
      lane_bits_reg <= lane_raw ^ pol_reg;
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else if (clk_en) begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_RESET)) | irq_event;
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= |(((irq_stat_reg & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_RESET)) | irq_event)
                   & (wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_reg));
    end
  end

  // Read mux
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      if (reg_addr == ADDR_LINK_CTRL) begin
        rdata_next[$bits(link_ctrl_t)-1:0] = ctrl_reg;
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        rdata_next[IRQ_W-1:0] = irq_stat_reg;
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        rdata_next[IRQ_W-1:0] = irq_mask_reg;
      end else if (reg_addr == ADDR_CRC_ALARM_THRESHOLDS) begin
        rdata_next[$bits(crc_alarm_thresholds_t)-1:0] = crc_alarm_thresholds_reg;
      end else if (reg_addr == ADDR_ARR_STAT) begin
        rdata_next[7:0] = {arr_rsvd_reg, ready_reg};
      end else if (reg_addr == ADDR_POL) begin
        rdata_next = pol_reg;
      end else if (reg_addr[ADDR_W-1:ARR_IDX_W] == ADDR_ARR_BASE[ADDR_W-1:ARR_IDX_W]) begin
        rdata_next[ARR_W-1:0] = arr_reg[reg_addr[ARR_IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= rdata_next;
    end
  end

  assign lane_bits = lane_bits_reg;
  assign crc_alarm = alarm_reg;
  assign arrival_times_ready = ready_reg;
  assign link_enable = ctrl_reg.enable;
  assign link_soft_reset = ctrl_reg.soft_reset;
  assign irq = irq_reg;

  // Checks
  sequence err_mb_s;
    clk_en && err_mb;
  endsequence

  sequence clean_done_s;
    clk_en && clean_mb && (run_inc >= REC_COUNT[crc_alarm_thresholds_reg.rec]);
  endsequence

  sequence capture_s;
    clk_en && capture;
  endsequence

  alarm_at_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
    err_mb_s ##0 (err_inc >= THR_COUNT[crc_alarm_thresholds_reg.thr]) |=> crc_alarm)
    else $error("alarm not raised at threshold");

  alarm_below_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
    err_mb_s ##0 (err_inc < THR_COUNT[crc_alarm_thresholds_reg.thr]) ##0 !alarm_reg |=> !crc_alarm)
    else $error("alarm raised below threshold");

  clean_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clean_done_s |=> (err_cnt_reg == '0) && !crc_alarm)
    else $error("clean run did not clear counter and alarm");

  err_count_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    err_mb_s ##0 (err_cnt_reg != ERR_MAX) |=> err_cnt_reg == $past(err_cnt_reg) + ERR_ONE)
    else $error("errored multiblock not counted");

  ready_on_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture_s ##0 ctrl_reg.enable ##0 !ctrl_reg.soft_reset |=> arrival_times_ready)
    else $error("ready flag not set on capture");

  capture_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture_s |=> arr_reg[0] == $past(lane_arrival_in[0]) && arr_reg[LANES-1] == $past(lane_arrival_in[LANES-1]))
    else $error("arrival times not captured");

  ready_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && (!ctrl_reg.enable || ctrl_reg.soft_reset) |=> !arrival_times_ready)
    else $error("ready flag not cleared");

  arrival_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ready_reg && $past(ready_reg) |-> $stable(arr_reg[0]))
    else $error("arrival time changed while ready");

  polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> lane_bits == $past(lane_raw ^ pol_reg))
    else $error("lane polarity not applied");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !reg_wr |=> irq == |((($past(irq_stat_reg)) | $past(irq_event)) & $past(irq_mask_reg)))
    else $error("interrupt level wrong");

  alarm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && crc_alarm && link_on && !clean_mb |=> crc_alarm)
    else $error("alarm dropped before clean run");

  run_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && clean_mb && (run_inc < REC_COUNT[crc_alarm_thresholds_reg.rec]) |=> run_cnt_reg == $past(run_inc))
    else $error("clean run not counted");

  capture_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ready_reg && lanes_ready && release_try |=> $stable(arr_reg[LANES-1]))
    else $error("arrival times recaptured while ready");

  ready_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture_s |=> irq_stat_reg[IRQ_READY])
    else $error("ready event not recorded");

  alarm_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && irq_event[IRQ_ALARM] |=> irq_stat_reg[IRQ_ALARM])
    else $error("alarm event lost against clear");

  link_off_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !link_on |=> !crc_alarm && (err_cnt_reg == '0) && (run_cnt_reg == '0))
    else $error("link off did not clear alarm state");

  idle_rdata_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero when idle");

  enable_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(lane_bits) && $stable(reg_rdata) && $stable(crc_alarm) && $stable(irq))
    else $error("state changed while clock enable low");

endmodule
`default_nettype wire

// File: serial_rx_crc_alarm_lane_status_bench.sv
// Self-checking bench for the CRC alarm, arrival status and lane inversion block
`timescale 1ns/1ps
`default_nettype none
module serial_rx_crc_alarm_lane_status_bench
  import serial_rx_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [LANES-1:0] lane_raw, lane_bits, raw_d, pol, held;
  mb_report_t mb_report;
  logic lanes_ready, release_try, crc_alarm, arrival_times_ready, link_enable, link_soft_reset, irq;
  logic [LANES-1:0][ARR_W-1:0] lane_arrival_in;
  logic mb_go = 1'b0;
  logic mb_bad = 1'b0;
  logic align_go = 1'b0;
  logic [ARR_W-1:0] arr_base = '0;
  logic [ARR_W-1:0] b0, ab;
  logic rd_d = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  int nt, nr;

  serial_rx_crc_alarm_lane_status serial_rx_crc_alarm_lane_status_inst (.clk, .rst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_raw, .lane_bits, .mb_report, .lanes_ready,
    .release_try, .lane_arrival_in, .crc_alarm, .arrival_times_ready, .link_enable, .link_soft_reset, .irq);
  serial_tx_model serial_tx_model_inst (.clk, .rst_n, .mb_go, .mb_bad, .align_go, .arr_base, .mb_report,
    .lane_raw, .lanes_ready, .release_try, .lane_arrival_in);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic ck(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic mb(input logic b);
    @(posedge clk);
    mb_go <= 1'b1;
    mb_bad <= b;
    @(posedge clk);
    mb_go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic align();
    @(posedge clk);
    align_go <= 1'b1;
    @(posedge clk);
    align_go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data checked one cycle after each read strobe
  always @(posedge clk) begin
    if (rd_d) ck(reg_rdata, exp_q.pop_front(), "read data");
    else if (rst_n) ck(reg_rdata, 16'h0000, "idle read data");
    rd_d <= reg_rd;
    raw_d <= lane_raw;
  end

  initial begin
    #500us;
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h44334c14));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_LINK_CTRL, 16'h0000);
    rd(ADDR_CRC_ALARM_THRESHOLDS, 16'h0000);
    rd(ADDR_ARR_STAT, 16'h0000);
    rd(ADDR_POL, 16'h0000);
    rd(ADDR_IRQ_STAT, 16'h0000);
    rd(12'h1fe, 16'h0000);
    $display("test reset values done");
    pol = DATA_W'($urandom);
    wr(ADDR_POL, pol);
    rd(ADDR_POL, pol);
    repeat (16) begin
      @(negedge clk);
      ck(lane_bits, raw_d ^ pol, "lane bits");
    end
    $display("test lane inversion done");
    @(posedge clk);
    clk_en <= 1'b0;
    @(negedge clk);
    held = raw_d ^ pol;
    wr(ADDR_POL, ~pol);
    repeat (4) begin
      @(negedge clk);
      ck(lane_bits, held, "lane bits frozen");
    end
    @(posedge clk);
    clk_en <= 1'b1;
    rd(ADDR_POL, pol);
    $display("test clock enable done");
    for (int c = 0; c < 4; c++) begin
      nt = 1 << c;
      nr = 1 << (2 * c);
      wr(ADDR_CRC_ALARM_THRESHOLDS, DATA_W'(8'hf0 | (c << 2) | c));
      rd(ADDR_CRC_ALARM_THRESHOLDS, DATA_W'(8'hf0 | (c << 2) | c));
      wr(ADDR_LINK_CTRL, 16'h0001);
      for (int e = 1; e <= nt; e++) begin
        mb(1'b1);
        ck(16'(crc_alarm), 16'(e == nt), "alarm on count");
        for (int k = 1; k < nr && e < nt; k++) mb(1'b0);
      end
      for (int k = 1; k <= nr; k++) begin
        ck(16'(crc_alarm), 16'h0001, "alarm held");
        mb(1'b0);
      end
      ck(16'(crc_alarm), 16'h0000, "alarm cleared");
      rd(ADDR_IRQ_STAT, 16'h0001);
      @(negedge clk);
      ck(16'(irq), 16'h0000, "irq masked");
      wr(ADDR_IRQ_MASK, 16'h0003);
      @(negedge clk);
      ck(16'(irq), 16'h0001, "irq raised");
      wr(ADDR_IRQ_STAT, 16'h0001);
      rd(ADDR_IRQ_STAT, 16'h0000);
      @(negedge clk);
      ck(16'(irq), 16'h0000, "irq cleared");
      wr(ADDR_IRQ_MASK, 16'h0000);
      mb(1'b1);
      ck(16'(crc_alarm), 16'(nt == 1), "count restarted");
      wr(ADDR_LINK_CTRL, 16'h0000);
    end
    $display("test crc alarm done");
    wr(ADDR_LINK_CTRL, 16'h0001);
    for (int t = 0; t < 2; t++) begin
      ab = ARR_W'($urandom);
      if (t == 0) b0 = ab;
      arr_base <= ab;
      align();
      rd(ADDR_ARR_STAT, 16'h0001);
      for (int n = 0; n < LANES; n++) rd(ADDR_ARR_BASE + ADDR_W'(n), DATA_W'(ARR_W'(b0 + 3 * n)));
    end
    rd(ADDR_IRQ_STAT, 16'h0002);
    wr(ADDR_ARR_STAT, 16'h00fe);
    rd(ADDR_ARR_STAT, 16'h00ff);
    wr(ADDR_LINK_CTRL, 16'h0003);
    @(negedge clk);
    ck(16'({link_soft_reset, link_enable}), 16'h0003, "link controls");
    align();
    rd(ADDR_ARR_STAT, 16'h00fe);
    wr(ADDR_LINK_CTRL, 16'h0001);
    align();
    rd(ADDR_ARR_STAT, 16'h00ff);
    @(negedge clk);
    ck(16'(arrival_times_ready), 16'h0001, "ready output");
    for (int n = 0; n < LANES; n++) rd(ADDR_ARR_BASE + ADDR_W'(n), DATA_W'(ARR_W'(ab + 3 * n)));
    wr(ADDR_LINK_CTRL, 16'h0000);
    rd(ADDR_ARR_STAT, 16'h00fe);
    repeat (2) @(posedge clk);
    $display("test arrival status done");
    complete_run();
  end
endmodule
`default_nettype wire

// File: serial_rx_pkg.sv
// Constants, field layouts and carrier types for the receive CRC alarm and lane status block
`default_nettype none
package serial_rx_pkg;
  localparam int LANES = 16;
  localparam int ARR_W = 6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int ARR_IDX_W = 4;
  localparam int IRQ_W = 2;
  localparam int ERR_W = 4;
  localparam int RUN_W = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_LINK_CTRL = 12'h100;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h104;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h106;
  localparam logic [ADDR_W-1:0] ADDR_CRC_ALARM_THRESHOLDS = 12'h128;
  localparam logic [ADDR_W-1:0] ADDR_ARR_STAT = 12'h12c;
  localparam logic [ADDR_W-1:0] ADDR_POL = 12'h12e;
  localparam logic [ADDR_W-1:0] ADDR_ARR_BASE = 12'h140;

  // Interrupt bit positions
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_READY = 1;

  // Threshold field layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] rec;
    logic [1:0] thr;
  } crc_alarm_thresholds_t;

  typedef struct packed {
    logic soft_reset;
    logic enable;
  } link_ctrl_t;

  // One multiblock verdict from the CRC checker
  typedef struct packed {
    logic valid;
    logic crc_err;
  } mb_report_t;

  localparam crc_alarm_thresholds_t CRC_ALARM_THRESHOLDS_RESET = 8'h00;
  localparam link_ctrl_t LINK_CTRL_RESET = 2'h0;
  localparam logic [DATA_W-1:0] POL_RESET = 16'h0000;
  localparam logic [6:0] ARR_RSVD_RESET = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam logic [ERR_W-1:0] ERR_MAX = 4'hf;
  localparam logic [ERR_W-1:0] ERR_ONE = 4'h1;
  localparam logic [RUN_W-1:0] RUN_ONE = 7'h01;
  localparam logic [ARR_W-1:0] ARR_RESET = 6'h00;

  // Code to count lookups
  localparam logic [ERR_W-1:0] THR_COUNT [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  localparam logic [RUN_W-1:0] REC_COUNT [4] = '{7'h01, 7'h04, 7'h10, 7'h40};
endpackage
`default_nettype wire

// File: serial_tx_model.sv
// Behavioural far-side transmitter: lane bits, multiblock verdicts, alignment
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model
  import serial_rx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands from the bench
  input wire logic mb_go,
  input wire logic mb_bad,
  input wire logic align_go,
  input wire logic [ARR_W-1:0] arr_base,
  // Link side
  output mb_report_t mb_report,
  output logic [LANES-1:0] lane_raw,
  output logic lanes_ready,
  output logic release_try,
  output logic [LANES-1:0][ARR_W-1:0] lane_arrival_in
);
  // Fresh bits every cycle, so a stale lane never looks right
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_raw <= '0;
      mb_report <= '0;
      lanes_ready <= 1'b0;
      release_try <= 1'b0;
    end else begin
      lane_raw <= LANES'($urandom);
      mb_report <= '{valid: mb_go, crc_err: mb_bad};
      lanes_ready <= align_go;
      release_try <= align_go;
    end
  end

  // Arrival times spread over lanes, live and always moving with the base
  always_comb begin
    for (int n = 0; n < LANES; n++) begin
      lane_arrival_in[n] = arr_base + ARR_W'(3 * n);
    end
  end
endmodule
`default_nettype wire
